// >>> vdsc_pkg.sv
/*
 * Package of the video DAC sync, blank and mode control block: constants, codes and the state type.
 * Assumes nothing of its surroundings; imported whole by every design file.
 */
package vdsc_pkg;

    localparam int unsigned VDSC_DATA_W   = 10;
    localparam int unsigned VDSC_NUM_CH   = 3;

    // Channel order on the per-channel vectors.
    localparam int unsigned VDSC_CH_RED   = 0;
    localparam int unsigned VDSC_CH_GREEN = 1;
    localparam int unsigned VDSC_CH_BLUE  = 2;

    // Blanking codes.
    localparam logic [9:0] VDSC_BLANK_FULL    = 10'h000;
    localparam logic [9:0] VDSC_BLANK_REDUCED = 10'h040;
    localparam logic [9:0] VDSC_BLANK_MID     = 10'h200;

    // Color space code carried on format_select_a: high selects YCbCr.
    localparam logic VDSC_FMT_A_YCBCR = 1'b1;

    // Reset values of the sampled configuration bits.
    localparam logic VDSC_RST_FMT_A     = 1'b0;
    localparam logic VDSC_RST_FMT_B     = 1'b0;
    localparam logic VDSC_RST_REDUCED   = 1'b0;
    localparam logic VDSC_RST_SYNC_ALL  = 1'b0;

    // Output level codes driven towards the analog section.
    typedef enum logic [1:0] {
        VDSC_LVL_DATA     = 2'b00,
        VDSC_LVL_BLANK    = 2'b01,
        VDSC_LVL_SYNC_NEG = 2'b10,
        VDSC_LVL_SYNC_POS = 2'b11
    } vdsc_level_t;

    // Sampling of the mode pins after a sync transition.
    typedef enum logic [1:0] {
        VDSC_SMP_IDLE  = 2'b00,
        VDSC_SMP_WAIT  = 2'b01,
        VDSC_SMP_TAKE  = 2'b10
    } vdsc_smp_state_t;

endpackage : vdsc_pkg

// >>> vdsc_mode_sampler.sv
/*
 * Mode pin sampler: loads the four internal configuration bits from the two mode pins.
 * Assumes registered sync from the top module and the raw mode pins, on the same clock.
 */
`timescale 1ns/100ps

module vdsc_mode_sampler
    import vdsc_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Registered sync and mode decode, raw mode pins
    input  wire logic sync_n_q,
    input  wire logic generic_mode,
    input  wire logic mode_pin_a,
    input  wire logic mode_pin_b,
    // Configuration bits
    output logic      format_select_a,
    output logic      format_select_b,
    output logic      reduced_range_select,
    output logic      sync_on_all_select
);

    typedef struct packed {
        vdsc_smp_state_t smp;
        logic            sync_prev;
        logic            rose;
        logic            fmt_a;
        logic            fmt_b;
        logic            reduced;
        logic            sync_all;
    } vdsc_smp_t;

    vdsc_smp_t st;
    vdsc_smp_t next_st;

    always_comb begin
        next_st           = st;
        next_st.sync_prev = sync_n_q;
        unique case (st.smp)
            VDSC_SMP_IDLE: ;
            VDSC_SMP_WAIT: next_st.smp = VDSC_SMP_TAKE;
            VDSC_SMP_TAKE: begin
                next_st.smp = VDSC_SMP_IDLE;
                if (!generic_mode) begin
                    if (st.rose) begin
                        next_st.fmt_a = mode_pin_a;
                        next_st.fmt_b = mode_pin_b;
                    end else begin
                        next_st.reduced  = mode_pin_a;
                        next_st.sync_all = mode_pin_b;
                    end
                end
            end
            default: next_st.smp = VDSC_SMP_IDLE;
        endcase
        // A transition goes straight to TAKE; one seen during TAKE lets that load finish and queues another.
        if (sync_n_q != st.sync_prev) begin
            next_st.smp  = VDSC_SMP_TAKE;
            next_st.rose = sync_n_q;
        end
    end

    // Raw pin edge t is seen as a register change at edge t; that change is caught
    // at t+1 and loading at t+2 takes the pins sampled at the second edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_st_reset: begin
                st.smp       <= VDSC_SMP_IDLE;
                st.sync_prev <= 1'b1;
                st.rose      <= 1'b0;
                st.fmt_a     <= VDSC_RST_FMT_A;
                st.fmt_b     <= VDSC_RST_FMT_B;
                st.reduced   <= VDSC_RST_REDUCED;
                st.sync_all  <= VDSC_RST_SYNC_ALL;
            end
        end else begin
            st <= next_st;
        end
    end

    // Generic mode reads the pins continuously and drops range and sync-all.
    always_comb begin
        format_select_a      = generic_mode ? mode_pin_a : st.fmt_a;
        format_select_b      = generic_mode ? mode_pin_b : st.fmt_b;
        reduced_range_select = generic_mode ? 1'b0 : st.reduced;
        sync_on_all_select   = generic_mode ? 1'b0 : st.sync_all;
    end

endmodule // vdsc_mode_sampler

// >>> vdsc_channel.sv
/*
 * One output channel: picks data, blanking code or sync level and the dc bias flag.
 * Assumes registered controls from the top module; the top registers the outputs.
 */
`timescale 1ns/100ps

module vdsc_channel
    import vdsc_pkg::*;
(
    // Registered pixel and controls
    input  wire logic [9:0]  data_q,
    input  wire logic        sync_active,
    input  wire logic        sync_pos,
    input  wire logic        blank_active,
    input  wire logic        sync_here,
    input  wire logic        mid_blank,
    input  wire logic        reduced_range,
    input  wire logic        generic_mode,
    input  wire logic        bias_capable,
    // Result
    output logic [9:0]       code,
    output vdsc_level_t      level,
    output logic             bias
);

    always_comb begin
        code  = data_q;
        level = VDSC_LVL_DATA;
        if (mid_blank) begin
            code = VDSC_BLANK_MID;
        end else if (reduced_range) begin
            code = VDSC_BLANK_REDUCED;
        end else begin
            code = VDSC_BLANK_FULL;
        end
        // Sync wins over blanking; generic mode never inserts sync.
        if (sync_active && sync_here && !generic_mode) begin
            level = sync_pos ? VDSC_LVL_SYNC_POS : VDSC_LVL_SYNC_NEG;
        end else if (blank_active) begin
            level = VDSC_LVL_BLANK;
        end else begin
            code = data_q;
        end
        bias = bias_capable && !generic_mode;
    end

endmodule // vdsc_channel

// >>> vdsc_top.sv
/*
 * Top of the video DAC sync, blank and mode control block: input registers,
 * mode decode, per-channel output selection and the APB register slave.
 * Assumes all pins are synchronous to pclk and an APB master on the same clock.
 */
`timescale 1ns/100ps

module vdsc_top
    import vdsc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Video timing and pixel inputs
    input  wire logic [9:0]  red_cr_data_in,
    input  wire logic [9:0]  green_luma_data_in,
    input  wire logic [9:0]  blue_cb_data_in,
    input  wire logic        blank_n,
    input  wire logic        sync_n,
    input  wire logic        sync_tri_level,
    input  wire logic        mode_pin_a,
    input  wire logic        mode_pin_b,
    // Digital codes and levels towards the analog section
    output logic [9:0]       red_cr_output,
    output logic [9:0]       green_luma_output,
    output logic [9:0]       blue_cb_output,
    output vdsc_level_t      red_cr_level,
    output vdsc_level_t      green_luma_level,
    output vdsc_level_t      blue_cb_level,
    output logic [2:0]       dc_bias_on,
    output logic             generic_mode_out
);

    localparam logic [11:0] VDSC_ADDR_CTRL   = 12'h000;
    localparam logic [11:0] VDSC_ADDR_STATUS = 12'h004;
    localparam int unsigned VDSC_CTRL_YCBCR  = 0;
    localparam int unsigned VDSC_ST_GENERIC  = 0;
    localparam int unsigned VDSC_ST_FMT_A    = 1;
    localparam int unsigned VDSC_ST_FMT_B    = 2;
    localparam int unsigned VDSC_ST_REDUCED  = 3;
    localparam int unsigned VDSC_ST_SYNCALL  = 4;
    localparam int unsigned VDSC_ST_SYNC     = 5;
    localparam int unsigned VDSC_ST_BLANK    = 6;
    localparam logic        VDSC_RST_YCBCR   = 1'b0;

    typedef struct packed {
        logic [2:0][9:0]      data_q;
        logic                 blank_n_q;
        logic                 sync_n_q;
        logic                 sync_t_q;
        logic                 ycbcr_sw;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
        logic [2:0][9:0]      out_code;
        logic [2:0][1:0]      out_level;
        logic [2:0]           bias;
        logic                 generic;
    } vdsc_top_state_t;

    vdsc_top_state_t st;
    vdsc_top_state_t next_st;

    logic                 generic_mode;
    logic                 fmt_a;
    logic                 fmt_b;
    logic                 reduced;
    logic                 sync_all;
    logic                 ycbcr;
    logic [2:0][9:0]      ch_code;
    vdsc_level_t [2:0]    ch_level;
    logic [2:0]           ch_bias;
    logic [2:0]           ch_sync_here;
    logic [2:0]           ch_mid;
    logic [2:0]           ch_bias_cap;
    logic                 apb_access;
    logic                 addr_ok;

    // Mode decode from the registered pins.
    assign generic_mode = st.sync_n_q && st.sync_t_q;

    vdsc_mode_sampler u_sampler (
        .pclk                 (pclk),
        .presetn              (presetn),
        .sync_n_q             (st.sync_n_q),
        .generic_mode         (generic_mode),
        .mode_pin_a           (mode_pin_a),
        .mode_pin_b           (mode_pin_b),
        .format_select_a      (fmt_a),
        .format_select_b      (fmt_b),
        .reduced_range_select (reduced),
        .sync_on_all_select   (sync_all)
    );

    // Color space follows format_select_a, or software may force YCbCr; kept in
    // generic mode as well.
    assign ycbcr = (fmt_a == VDSC_FMT_A_YCBCR) || st.ycbcr_sw;

    generate
        for (genvar ch = 0; ch < VDSC_NUM_CH; ch++) begin : g_ch
            // Sync on green always, on the others only when sync-on-all is set.
            assign ch_sync_here[ch] = (ch == VDSC_CH_GREEN) || sync_all;
            // Red and blue carry Cr and Cb in YCbCr and blank mid-range.
            assign ch_mid[ch]       = (ch != VDSC_CH_GREEN) && ycbcr;
            assign ch_bias_cap[ch]  = !ch_mid[ch];

            vdsc_channel u_ch (
                .data_q        (st.data_q[ch]),
                .sync_active   (!st.sync_n_q),
                .sync_pos      (st.sync_t_q),
                .blank_active  (!st.blank_n_q),
                .sync_here     (ch_sync_here[ch]),
                .mid_blank     (ch_mid[ch]),
                .reduced_range (reduced),
                .generic_mode  (generic_mode),
                .bias_capable  (ch_bias_cap[ch]),
                .code          (ch_code[ch]),
                .level         (ch_level[ch]),
                .bias          (ch_bias[ch])
            );
        end
    endgenerate

    assign apb_access = psel && penable;
    assign addr_ok    = (paddr == VDSC_ADDR_CTRL) || (paddr == VDSC_ADDR_STATUS);

    always_comb begin
        next_st = st;
        // Input registers.
        next_st.data_q[VDSC_CH_RED]   = red_cr_data_in;
        next_st.data_q[VDSC_CH_GREEN] = green_luma_data_in;
        next_st.data_q[VDSC_CH_BLUE]  = blue_cb_data_in;
        next_st.blank_n_q             = blank_n;
        next_st.sync_n_q              = sync_n;
        next_st.sync_t_q              = sync_tri_level;
        for (int i = 0; i < VDSC_NUM_CH; i++) begin
            next_st.out_code[i]  = ch_code[i];
            next_st.out_level[i] = ch_level[i];
        end
        next_st.bias    = ch_bias;
        next_st.generic = generic_mode;

        // APB: one wait state; pready pulses in the second access cycle.
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        if (apb_access && !st.pready) begin
            next_st.pready  = 1'b1;
            next_st.pslverr = !addr_ok;
            next_st.prdata  = 32'h0000_0000;
            if (pwrite) begin
                if (paddr == VDSC_ADDR_CTRL) begin
                    next_st.ycbcr_sw = pwdata[VDSC_CTRL_YCBCR];
                end
            end else if (paddr == VDSC_ADDR_CTRL) begin
                next_st.prdata[VDSC_CTRL_YCBCR] = st.ycbcr_sw;
            end else if (paddr == VDSC_ADDR_STATUS) begin
                next_st.prdata[VDSC_ST_GENERIC] = generic_mode;
                next_st.prdata[VDSC_ST_FMT_A]   = fmt_a;
                next_st.prdata[VDSC_ST_FMT_B]   = fmt_b;
                next_st.prdata[VDSC_ST_REDUCED] = reduced;
                next_st.prdata[VDSC_ST_SYNCALL] = sync_all;
                next_st.prdata[VDSC_ST_SYNC]    = !st.sync_n_q;
                next_st.prdata[VDSC_ST_BLANK]   = !st.blank_n_q;
            end
        end
    end

    // Idle pins reset to video mode, no sync and no blanking.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.data_q    <= '0;
            st.blank_n_q <= 1'b1;
            st.sync_n_q  <= 1'b1;
            st.sync_t_q  <= 1'b0;
            st.ycbcr_sw  <= VDSC_RST_YCBCR;
            st.prdata    <= 32'h0000_0000;
            st.pready    <= 1'b0;
            st.pslverr   <= 1'b0;
            st.out_code  <= '0;
            st.out_level <= '0;
            st.bias      <= '0;
            st.generic   <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        prdata            = st.prdata;
        pready            = st.pready;
        pslverr           = st.pslverr;
        red_cr_output     = st.out_code[VDSC_CH_RED];
        green_luma_output = st.out_code[VDSC_CH_GREEN];
        blue_cb_output    = st.out_code[VDSC_CH_BLUE];
        red_cr_level      = vdsc_level_t'(st.out_level[VDSC_CH_RED]);
        green_luma_level  = vdsc_level_t'(st.out_level[VDSC_CH_GREEN]);
        blue_cb_level     = vdsc_level_t'(st.out_level[VDSC_CH_BLUE]);
        dc_bias_on        = st.bias;
        generic_mode_out  = st.generic;
    end

endmodule // vdsc_top

// >>> vdsc_ctl_sva.sv
/*
 * Checker of the sync, blank and mode control block, bound into its top.
 * Assumes the two-cycle pin-to-output pipeline of the top on pclk.
 */
`timescale 1ns/100ps

module vdsc_ctl_sva
    import vdsc_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Pins
    input wire logic        sync_n,
    input wire logic        sync_tri_level,
    input wire logic        blank_n,
    input wire logic [9:0]  green_luma_data_in,
    // Outputs
    input wire logic [9:0]  red_cr_output,
    input wire logic [9:0]  green_luma_output,
    input wire vdsc_level_t red_cr_level,
    input wire vdsc_level_t green_luma_level,
    input wire vdsc_level_t blue_cb_level,
    input wire logic [2:0]  dc_bias_on,
    input wire logic        generic_mode_out,
    input wire logic        pready,
    input wire logic        pslverr
);
    // Pin history is meaningful only once three edges have passed after reset.
    logic [1:0] up;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            up <= 2'h0;
        else if (up != 2'h3)
            up <= up + 2'h1;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    gen_mode_a: assert property (up == 2'h3 |-> generic_mode_out == $past(sync_n & sync_tri_level, 2))
        else $error("generic flag does not follow sync and polarity");
    sync_neg_a: assert property (up == 2'h3 && $past(!sync_n && !sync_tri_level, 2)
        |-> green_luma_level == VDSC_LVL_SYNC_NEG)
        else $error("green output not at negative sync");
    sync_pos_a: assert property (up == 2'h3 && $past(!sync_n && sync_tri_level, 2)
        |-> green_luma_level == VDSC_LVL_SYNC_POS)
        else $error("green output not at positive sync");
    no_gen_sync_a: assert property (generic_mode_out |-> !red_cr_level[1] && !green_luma_level[1]
        && !blue_cb_level[1])
        else $error("sync level in generic mode");
    blank_all_a: assert property (up == 2'h3 && $past(sync_n && !blank_n, 2) |-> red_cr_level == VDSC_LVL_BLANK
        && green_luma_level == VDSC_LVL_BLANK && blue_cb_level == VDSC_LVL_BLANK)
        else $error("blanking not forced on every channel");
    data_pass_a: assert property (up == 2'h3 && $past(sync_n && blank_n, 2) |->
        green_luma_level == VDSC_LVL_DATA && green_luma_output == $past(green_luma_data_in, 2))
        else $error("pixel data not passed after two edges");
    bias_green_a: assert property (up == 2'h3 |-> dc_bias_on[1] == !generic_mode_out)
        else $error("green bias does not follow mode");
    red_blank_a: assert property (red_cr_level == VDSC_LVL_BLANK |->
        dc_bias_on[0] == (!generic_mode_out && red_cr_output != VDSC_BLANK_MID))
        else $error("red bias wrong while blanked");
    gen_full_a: assert property (generic_mode_out && green_luma_level == VDSC_LVL_BLANK
        |-> green_luma_output == VDSC_BLANK_FULL)
        else $error("generic blanking not at full range code");
    ready_pulse_a: assert property (pslverr |-> pready ##1 !pready)
        else $error("bus error not a one-cycle answer");
endmodule // vdsc_ctl_sva

bind vdsc_top vdsc_ctl_sva u_sva (.pclk(pclk), .presetn(presetn), .sync_n(sync_n),
    .sync_tri_level(sync_tri_level), .blank_n(blank_n), .green_luma_data_in(green_luma_data_in),
    .red_cr_output(red_cr_output), .green_luma_output(green_luma_output), .red_cr_level(red_cr_level),
    .green_luma_level(green_luma_level), .blue_cb_level(blue_cb_level), .dc_bias_on(dc_bias_on),
    .generic_mode_out(generic_mode_out), .pready(pready), .pslverr(pslverr));

// >>> vdsc_src_model.sv
/*
 * Video timing and pixel source: random sync intervals, tri-level pulses and blanking.
 * Assumes the bench holds run low while it drives the idle sync level itself.
 */
`timescale 1ns/100ps

module vdsc_src_model (
    // Control from the bench
    input  wire logic       pclk,
    input  wire logic       run,
    input  wire logic       gen_ok,
    input  wire logic       idle_sync_n,
    // Pins towards the block
    output wire logic       sync_n,
    output wire logic       sync_tri_level,
    output wire logic       blank_n,
    output wire logic [9:0] red_cr_data_in,
    output wire logic [9:0] green_luma_data_in,
    output wire logic [9:0] blue_cb_data_in
);
    logic       s_q = 1'b1;
    logic       t_q = 1'b0;
    logic       bk_q = 1'b1;
    logic       tl = 1'b0;
    logic [3:0] cnt = 4'h0;
    logic [9:0] r_q = 10'h000;
    logic [9:0] g_q = 10'h000;
    logic [9:0] b_q = 10'h000;

    assign sync_n = run ? s_q : idle_sync_n;
    assign sync_tri_level = run & t_q;
    assign blank_n = run ? bk_q : 1'b1;
    assign red_cr_data_in = r_q;
    assign green_luma_data_in = g_q;
    assign blue_cb_data_in = b_q;

    always @(posedge pclk) begin
        if (run) begin
            r_q <= 10'($urandom);
            g_q <= 10'($urandom);
            b_q <= 10'($urandom);
            bk_q <= $urandom_range(0, 3) != 0;
            if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
                if (!s_q && tl && cnt == 4'h2)
                    t_q <= 1'b1;
            end else if (s_q) begin
                s_q <= 1'b0;
                t_q <= 1'b0;
                tl <= 1'($urandom);
                cnt <= 4'($urandom_range(2, 8));
            end else begin
                s_q <= 1'b1;
                t_q <= gen_ok & 1'($urandom);
                cnt <= 4'($urandom_range(1, 6));
            end
        end
    end
endmodule // vdsc_src_model

// >>> vdsc_tb_top.sv
/*
 * Testbench of the sync, blank and mode control block: bus map, mode sampling, random traffic.
 * Assumes the source model file and the checker are compiled alongside.
 */
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; $display("unexpected %s exp %h got %h", n, e, a); end end

module vdsc_tb_top
    import vdsc_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    logic        err;
    logic        pin_a = 1'b0;
    logic        pin_b = 1'b0;
    logic        run = 1'b0;
    logic        gen_ok = 1'b0;
    logic        dsync = 1'b1;
    logic        chk = 1'b0;
    logic        ctl = 1'b0;
    logic [32:0] h1;
    logic [32:0] h2;
    logic [12:0] got [3];
    wire logic [31:0] prdata;
    wire logic        pready;
    wire logic        pslverr;
    wire logic [9:0]  r_in;
    wire logic [9:0]  g_in;
    wire logic [9:0]  b_in;
    wire logic [9:0]  r_out;
    wire logic [9:0]  g_out;
    wire logic [9:0]  b_out;
    vdsc_level_t      r_lv;
    vdsc_level_t      g_lv;
    vdsc_level_t      b_lv;
    wire logic [2:0]  bias;
    wire logic        gen;
    wire logic        sync_n;
    wire logic        tri_lv;
    wire logic        blank_n;
    int               num_errors = 0;
    int               checked = 0;

    always #50 pclk = ~pclk;

    vdsc_src_model src (.pclk(pclk), .run(run), .gen_ok(gen_ok), .idle_sync_n(dsync), .sync_n(sync_n),
        .sync_tri_level(tri_lv), .blank_n(blank_n), .red_cr_data_in(r_in), .green_luma_data_in(g_in),
        .blue_cb_data_in(b_in));

    vdsc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .red_cr_data_in(r_in), .green_luma_data_in(g_in), .blue_cb_data_in(b_in), .blank_n(blank_n),
        .sync_n(sync_n), .sync_tri_level(tri_lv), .mode_pin_a(pin_a), .mode_pin_b(pin_b),
        .red_cr_output(r_out), .green_luma_output(g_out), .blue_cb_output(b_out), .red_cr_level(r_lv),
        .green_luma_level(g_lv), .blue_cb_level(b_lv), .dc_bias_on(bias), .generic_mode_out(gen));

    // Expected {bias, level, code} of one channel from pins seen two edges back.
    function automatic logic [12:0] exp_ch(input int ch, input logic [32:0] h, input logic ycc,
                                           input logic red, input logic sa);
        logic       g;
        logic       mid;
        logic       bs;
        logic [9:0] bc;
        g = h[32] & h[31];
        mid = ycc && ch != 1;
        bs = !g && !mid;
        bc = mid ? VDSC_BLANK_MID : (red && !g) ? VDSC_BLANK_REDUCED : VDSC_BLANK_FULL;
        if (!g && !h[32] && (ch == 1 || sa))
            return {bs, h[31] ? VDSC_LVL_SYNC_POS : VDSC_LVL_SYNC_NEG, bc};
        if (!h[30])
            return {bs, VDSC_LVL_BLANK, bc};
        return {bs, VDSC_LVL_DATA, h[29 - 10 * ch -: 10]};
    endfunction

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int   n;
        logic ok;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Look at the answer once settled; the next rising edge is the one that samples it high.
        @(negedge pclk);
        while (pready !== 1'b1 && n < 10) begin
            @(negedge pclk);
            n++;
        end
        ok = pready === 1'b1;
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) begin
            num_errors++;
            finish_test();
        end
    endtask

    always @(posedge pclk) begin
        h1 <= {sync_n, tri_lv, blank_n, r_in, g_in, b_in};
        h2 <= h1;
    end

    // In random phases the pins stay put, so every stored bit equals its pin.
    always @(negedge pclk) begin
        if (chk) begin
            got[0] = {bias[0], r_lv, r_out};
            got[1] = {bias[1], g_lv, g_out};
            got[2] = {bias[2], b_lv, b_out};
            for (int c = 0; c < 3; c++)
                `CHK("channel", exp_ch(c, h2, pin_a | ctl, pin_a, pin_b), got[c])
            `CHK("generic", h2[32] & h2[31], gen)
        end
    end

    initial begin
        void'($urandom(96));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        `CHK("ctrl reset", 32'h0, rd)
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        `CHK("ctrl", 32'h1, rd)
        apb(1'b0, 12'h008, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        apb(1'b1, 12'h000, 32'h0);
        $display("register test done");
        // Pins are valid only around the sample edge and change right after it.
        @(posedge pclk);
        dsync <= 1'b0;
        repeat (2) @(posedge pclk);
        pin_a <= 1'b1;
        @(posedge pclk);
        pin_a <= 1'b0;
        pin_b <= 1'b1;
        repeat (4) @(posedge pclk);
        dsync <= 1'b1;
        repeat (3) @(posedge pclk);
        pin_a <= 1'b1;
        pin_b <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        `CHK("status", 32'h0c, rd)
        $display("mode sampling test done");
        for (int j = 0; j < 8; j++) begin
            @(posedge pclk);
            pin_a <= j[0];
            pin_b <= j[1];
            gen_ok <= j[2];
            ctl = 1'($urandom_range(0, 1));
            apb(1'b1, 12'h000, {31'h0, ctl});
            @(posedge pclk);
            dsync <= 1'b0;
            repeat (4) @(posedge pclk);
            dsync <= 1'b1;
            repeat (6) @(posedge pclk);
            chk <= 1'b1;
            run <= 1'b1;
            repeat (400) @(posedge pclk);
            run <= 1'b0;
            repeat (4) @(posedge pclk);
            chk <= 1'b0;
            $display("random phase %0d done", j);
        end
        finish_test();
    end
endmodule // vdsc_tb_top
